// [common/io_status_defs.vh]
// Constants for the eight-in / eight-out field module status logic
// How it works
// - Halted host: substitute mode drives substitute level
// - Output image bit n drives output n
// - Value status 1 only if level present
// - Fault lamp dark without backplane supply
// - Fault lamp flashes before parameters arrive
// - Fault lamp steady when parameterised, no diagnostics
// - Fault lamp flashes when diagnostics active
// - Input lamp follows input signal
// - Output lamp lit when activated and 1
// - Output lamp dark when off, 0 or faulted
// - Supply lamp follows field supply
// - Diagnostic interrupt on listed fault events
// - Each event gives message and flashing lamp
// - Codes: short-circuit 1, wire break 6
// - Input open circuit reports wire break
// - Output open circuit reports wire break
// - Codes: parameter error 10, supply 11
// - Update state: code 1F, no I/O
// - Disabled input channel is not processed
`ifndef IO_STATUS_DEFS_VH
`define IO_STATUS_DEFS_VH

`define NCH           8
`define CHAN_W        3
`define SYNC_W        50
`define OUT_IMAGE_RST 8'h00

// Stop reaction encodings, two bits per channel
`define STOP_OFF      2'h0
`define STOP_HOLD     2'h1
`define STOP_SUBST    2'h2

// Diagnostic error codes
`define CODE_SHORT    8'h01
`define CODE_WBREAK   8'h06
`define CODE_PARAM    8'h10
`define CODE_SUPPLY   8'h11
`define CODE_UPDATE   8'h1F

// Diagnostic source vector layout
`define SRC_W         27
`define SRC_IDX_W     5
`define SRC_SC_LO     5'h00
`define SRC_DIWB_LO   5'h08
`define SRC_DQWB_LO   5'h10
`define SRC_PARAM     5'h18
`define SRC_SUPPLY    5'h19
`define SRC_UPDATE    5'h1A

// Timing
`define CLK_PERIOD_NS 4
`define FLASH_HALF_MS 250

`endif

// [src/pin_sync.v]
// Two-stage synchroniser for asynchronous pin levels
module pin_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         rst,
  // Levels
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] stable_q;

  // First stage feeds only the second
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_q   <= {W{1'b0}};
      stable_q <= {W{1'b0}};
    end
    else
    begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule // pin_sync

// [src/flash_gen.v]
// Square wave for flashing lamps
module flash_gen #(
  parameter HALF_CYC = 62500000
) (
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Flash level
  output wire flash
);

  reg [31:0] cnt_q;
  reg        phase_q;

  // Toggle phase every half period
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q   <= 32'h00000000;
      phase_q <= 1'b0;
    end
    else if (cnt_q >= HALF_CYC - 1)
    begin
      cnt_q   <= 32'h00000000;
      phase_q <= ~phase_q;
    end
    else
    begin
      cnt_q   <= cnt_q + 32'h00000001;
    end
  end

  assign flash = phase_q;

endmodule // flash_gen

// [src/io_module_status_fault_lamp.v]
// Process image, value status, lamps and diagnostics of the I/O module
`include "io_status_defs.vh"

module io_module_status_fault_lamp #(
  parameter FLASH_HALF_CYC = `FLASH_HALF_MS * 1000000 / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         rst,
  // Host image exchange
  input  wire         out_image_wr,
  input  wire [7:0]   out_image_wdata,
  output wire [7:0]   output_image,
  output wire [7:0]   input_image,
  output wire [7:0]   value_status,
  // Host state and parameters
  input  wire         host_halted,
  input  wire         params_valid,
  input  wire         param_error,
  input  wire         fw_update,
  input  wire [7:0]   di_enable,
  input  wire [7:0]   dq_enable,
  input  wire [15:0]  stop_mode,
  input  wire [7:0]   subst_level,
  input  wire         fault_lamp_supply_en,
  input  wire         fault_lamp_di_wb_en,
  input  wire         fault_lamp_sc_gnd_en,
  input  wire         fault_lamp_sc_sup_en,
  input  wire         fault_lamp_dq_wb_en,
  // Terminal sense pins
  input  wire [7:0]   sensing_channel,
  input  wire [7:0]   in_open_pin,
  input  wire [7:0]   out_fb_pin,
  input  wire [7:0]   out_sc_gnd_pin,
  input  wire [7:0]   out_sc_sup_pin,
  input  wire [7:0]   out_open_pin,
  input  wire         field_supply_pin,
  input  wire         backplane_ok_pin,
  // Output drivers
  output wire [7:0]   out_drive,
  // Lamps
  output wire         fault_lamp,
  output wire         supply_lamp,
  output wire [7:0]   in_lamp,
  output wire [7:0]   out_lamp,
  // Diagnostic messages
  output wire         fault_lamp_irq,
  output wire [7:0]   fault_lamp_code,
  output wire [2:0]   fault_lamp_chan,
  output wire         fault_lamp_active
);

  // Synchronised pin levels
  wire [`SYNC_W-1:0] pins_s;
  wire [7:0]         in_s;
  wire [7:0]         in_open_s;
  wire [7:0]         fb_s;
  wire [7:0]         sc_gnd_s;
  wire [7:0]         sc_sup_s;
  wire [7:0]         out_open_s;
  wire               supply_s;
  wire               backplane_s;
  wire               flash;

  // Registers
  reg  [7:0]         out_image_q;
  reg  [7:0]         out_drive_q;
  reg  [7:0]         out_drive_d;
  reg  [7:0]         in_image_q;
  reg  [7:0]         qi_q;
  reg  [`SRC_W-1:0]  reported_q;
  reg                irq_q;
  reg  [7:0]         code_q;
  reg  [2:0]         chan_q;
  reg                fault_lamp_q;
  reg                supply_lamp_q;
  reg  [7:0]         in_lamp_q;
  reg  [7:0]         out_lamp_q;
  // Fills with ones as the pin synchroniser fills after reset
  reg  [1:0]         warm_q;
  wire               sync_full;

  // Diagnostic sources
  wire [7:0]         sc_chan;
  wire [7:0]         di_wb;
  wire [7:0]         dq_wb;
  wire [7:0]         chan_fault;
  wire [`SRC_W-1:0]  cond;
  wire [`SRC_W-1:0]  pending;
  wire [`SRC_IDX_W-1:0] pick;
  wire               any_active;

  integer            k;

  // Error code for a source index
  function [7:0] code_of;
    input [`SRC_IDX_W-1:0] idx;
    begin
      if (idx < `SRC_DIWB_LO)
        code_of = `CODE_SHORT;
      else if (idx < `SRC_PARAM)
        code_of = `CODE_WBREAK;
      else if (idx == `SRC_PARAM)
        code_of = `CODE_PARAM;
      else if (idx == `SRC_SUPPLY)
        code_of = `CODE_SUPPLY;
      else
        code_of = `CODE_UPDATE;
    end
  endfunction

  // Channel number for a source index, zero for module events
  function [2:0] chan_of;
    input [`SRC_IDX_W-1:0] idx;
    begin
      if (idx < `SRC_PARAM)
        chan_of = idx[2:0];
      else
        chan_of = 3'h0;
    end
  endfunction

  // Lowest set bit of a source vector
  function [`SRC_IDX_W-1:0] first_set;
    input [`SRC_W-1:0] vec;
    integer i;
    begin
      first_set = {`SRC_IDX_W{1'b0}};
      for (i = `SRC_W - 1; i >= 0; i = i - 1)
        if (vec[i])
          first_set = i[`SRC_IDX_W-1:0];
    end
  endfunction

  // Pin synchroniser
  pin_sync #(
    .W        (`SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({backplane_ok_pin, field_supply_pin, out_open_pin,
                out_sc_sup_pin, out_sc_gnd_pin, out_fb_pin,
                in_open_pin, sensing_channel}),
    .sync_out (pins_s)
  );

  assign in_s        = pins_s[7:0];
  assign in_open_s   = pins_s[15:8];
  assign fb_s        = pins_s[23:16];
  assign sc_gnd_s    = pins_s[31:24];
  assign sc_sup_s    = pins_s[39:32];
  assign out_open_s  = pins_s[47:40];
  assign supply_s    = pins_s[48];
  assign backplane_s = pins_s[49];

  // Synchroniser fill tracker: pins read as the reset level
  // for two edges after reset, which would look like a lost
  // field supply and raise a false start-up message
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      warm_q <= 2'h0;
    else
      warm_q <= {warm_q[0], 1'b1};
  end

  // Synchronised levels are real from here on
  assign sync_full = warm_q[1];

  // Lamp flash source
  flash_gen #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_flash (
    .mclk     (mclk),
    .rst      (rst),
    .flash    (flash)
  );

  // Output image register
  // host byte store
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      out_image_q <= `OUT_IMAGE_RST;
    else if (out_image_wr)
      out_image_q <= out_image_wdata;
  end

  // Next output drive per channel
  always @*
  begin
    out_drive_d = 8'h00;
    for (k = 0; k < `NCH; k = k + 1)
    begin
      if (fw_update)
        out_drive_d[k] = 1'b0;
      else if (!dq_enable[k])
        out_drive_d[k] = 1'b0;
      else if (host_halted)
      begin
        case (stop_mode[2*k +: 2])
          `STOP_HOLD:
            out_drive_d[k] = out_drive_q[k];
          `STOP_SUBST:
            out_drive_d[k] = subst_level[k];
          default:
            out_drive_d[k] = 1'b0;
        endcase
      end
      else
        out_drive_d[k] = out_image_q[k];
    end
  end

  // Output driver register
  // update blocks outputs
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      out_drive_q <= 8'h00;
    else
      out_drive_q <= out_drive_d;
  end

  // Input image register, frozen during update
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      in_image_q <= 8'h00;
    else if (!fw_update)
      in_image_q <= in_s & di_enable;
  end

  // Per-channel fault sources
  // input wire break
  assign di_wb = in_open_s & di_enable & {`NCH{fault_lamp_di_wb_en}};
  assign dq_wb = out_open_s & dq_enable & {`NCH{fault_lamp_dq_wb_en}};
  assign sc_chan = dq_enable & ((sc_gnd_s & {`NCH{fault_lamp_sc_gnd_en}}) |
                                (sc_sup_s & {`NCH{fault_lamp_sc_sup_en}}));
  assign chan_fault = sc_chan | dq_wb;

  // Diagnostic condition vector
  // all event kinds
  // Supply event masked until synchroniser has filled
  assign cond = {fw_update,
                 ~supply_s & sync_full & fault_lamp_supply_en,
                 param_error,
                 dq_wb, di_wb, sc_chan};

  assign pending    = cond & ~reported_q;
  assign pick       = first_set(pending);
  assign any_active = |cond;

  // Value status: commanded level really at terminal
  // readback compare
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      qi_q <= 8'h00;
    else if (fw_update)
      qi_q <= 8'h00;
    else
      qi_q <= dq_enable & ~(fb_s ^ out_drive_q) & ~chan_fault
              & {`NCH{supply_s}};
  end

  // Message emitter, one event per cycle
  // coded messages
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reported_q <= {`SRC_W{1'b0}};
      irq_q      <= 1'b0;
      code_q     <= 8'h00;
      chan_q     <= 3'h0;
    end
    else
    begin
      // Cleared when source goes away, set on emission
      reported_q <= (reported_q & cond) |
                    ((|pending) ? ({{(`SRC_W-1){1'b0}}, 1'b1} << pick)
                                : {`SRC_W{1'b0}});
      irq_q      <= |pending;
      if (|pending)
      begin
        code_q <= code_of(pick);
        chan_q <= chan_of(pick);
      end
    end
  end

  // Lamp registers
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fault_lamp_q  <= 1'b0;
      supply_lamp_q <= 1'b0;
      in_lamp_q     <= 8'h00;
      out_lamp_q    <= 8'h00;
    end
    else
    begin
      if (!backplane_s)
        fault_lamp_q <= 1'b0;
      else if (!params_valid)
        fault_lamp_q <= flash;
      else if (any_active)
        fault_lamp_q <= flash;
      else
        fault_lamp_q <= 1'b1;
      supply_lamp_q <= supply_s;
      in_lamp_q     <= in_image_q;
      out_lamp_q    <= dq_enable & out_drive_q & ~chan_fault;
    end
  end

  // Output assignments
  assign output_image = out_image_q;
  assign input_image  = in_image_q;
  assign value_status = qi_q;
  assign out_drive    = out_drive_q;
  assign fault_lamp   = fault_lamp_q;
  assign supply_lamp  = supply_lamp_q;
  assign in_lamp      = in_lamp_q;
  assign out_lamp     = out_lamp_q;
  assign fault_lamp_irq     = irq_q;
  assign fault_lamp_code    = code_q;
  assign fault_lamp_chan    = chan_q;
  assign fault_lamp_active  = any_active;

endmodule // io_module_status_fault_lamp

// [bench/field_model.sv]
// Field wiring model of the output terminals
module field_model (
  // Commanded drive
  input  logic [7:0] out_drive,
  // Injected wiring faults
  input  logic [7:0] stuck,
  input  logic [7:0] gnd_fault,
  input  logic [7:0] open_fault,
  // Terminal sense lines
  output logic [7:0] out_fb_pin,
  output logic [7:0] out_sc_gnd_pin,
  output logic [7:0] out_open_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign out_fb_pin     = (out_drive & ~gnd_fault) ^ stuck;
  // Fault sense lines
  assign out_sc_gnd_pin = gnd_fault;
  assign out_open_pin   = open_fault;
endmodule // field_model

// [bench/io_status_chk.sv]
// Port checks of the status and diagnostic block
module io_status_chk (
  // Clock and reset
  input logic       mclk,
  input logic       rst,
  // Image and drive
  input logic       out_image_wr,
  input logic [7:0] out_image_wdata,
  input logic [7:0] output_image,
  input logic [7:0] out_drive,
  input logic [7:0] value_status,
  // State, supplies, lamps, messages
  input logic       fw_update,
  input logic       params_valid,
  input logic       backplane_ok_pin,
  input logic       field_supply_pin,
  input logic       fault_lamp,
  input logic       supply_lamp,
  input logic       fault_lamp_active,
  input logic       fault_lamp_irq,
  input logic [7:0] fault_lamp_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_image_store: assert property (out_image_wr |=> output_image == $past(out_image_wdata))
    else $error("image not stored");
  a_update_quiet: assert property (fw_update [*4] |-> out_drive == 8'h00 && value_status == 8'h00)
    else $error("outputs live in update");
  a_lamp_dark: assert property (!backplane_ok_pin [*4] |-> !fault_lamp)
    else $error("fault lamp lit");
  a_lamp_steady: assert property ((backplane_ok_pin && params_valid && !fault_lamp_active) [*4] |-> fault_lamp)
    else $error("fault lamp not steady");
  a_supply_on: assert property (field_supply_pin [*4] |-> supply_lamp)
    else $error("supply lamp dark");
  a_supply_off: assert property (!field_supply_pin [*4] |-> !supply_lamp)
    else $error("supply lamp lit");
  a_code_known: assert property (fault_lamp_irq |-> fault_lamp_code inside {8'h01, 8'h06, 8'h10, 8'h11, 8'h1F})
    else $error("unknown code");
  a_code_update: assert property (fault_lamp_irq && fault_lamp_code == 8'h1F |-> $past(fw_update))
    else $error("update code without update");
  c_wire_break: cover property (fault_lamp_irq && fault_lamp_code == 8'h06);
  c_short: cover property (fault_lamp_irq && fault_lamp_code == 8'h01);
  c_flash: cover property (fault_lamp ##1 !fault_lamp);
endmodule // io_status_chk

bind io_module_status_fault_lamp io_status_chk u_io_status_chk (.mclk, .rst, .out_image_wr, .out_image_wdata,
  .output_image, .out_drive, .value_status, .fw_update, .params_valid, .backplane_ok_pin, .field_supply_pin,
  .fault_lamp, .supply_lamp, .fault_lamp_active, .fault_lamp_irq, .fault_lamp_code);

// [bench/testbench.sv]
// Self-checking bench for the status and diagnostic block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Design inputs
  logic        mclk = 1'h0, rst = 1'h1, out_image_wr = 1'h0, host_halted = 1'h0, params_valid = 1'h0;
  logic        param_error = 1'h0, fw_update = 1'h0, field_supply_pin = 1'h1, backplane_ok_pin = 1'h1;
  logic        fault_lamp_supply_en = 1'h1, fault_lamp_di_wb_en = 1'h1, fault_lamp_sc_gnd_en = 1'h1;
  logic        fault_lamp_sc_sup_en = 1'h0, fault_lamp_dq_wb_en = 1'h1;
  logic [7:0]  out_image_wdata = 8'h00, di_enable = 8'hFF, dq_enable = 8'hFF, subst_level = 8'h00;
  logic [7:0]  sensing_channel = 8'h00, in_open_pin = 8'h00, out_sc_sup_pin = 8'h00;
  logic [7:0]  stuck = 8'h00, gnd_fault = 8'h00, open_fault = 8'h00;
  logic [15:0] stop_mode = 16'h0000;
  // Design outputs
  wire  [7:0]  output_image, input_image, value_status, out_drive, in_lamp, out_lamp, fault_lamp_code;
  wire  [7:0]  out_fb_pin, out_sc_gnd_pin, out_open_pin;
  wire  [2:0]  fault_lamp_chan;
  wire         fault_lamp, supply_lamp, fault_lamp_irq, fault_lamp_active;
  int          num_errors = 0, cmp_count = 0, cycles = 0;
  logic [7:0]  ev_code [7] = '{8'h06, 8'h06, 8'h01, 8'h01, 8'h10, 8'h11, 8'h1F};
  logic [7:0]  ev_chan [7] = '{8'h02, 8'h05, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00};

  io_module_status_fault_lamp #(.FLASH_HALF_CYC(4)) u_io_module_status_fault_lamp (.*);
  field_model u_field_model (.*);

  // Clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Host output image write, one strobe cycle
  task automatic write_image(input logic [7:0] d);
    tick(1);
    out_image_wr = 1'h1;
    out_image_wdata = d;
    tick(1);
    out_image_wr = 1'h0;
  endtask

  // Both lamp levels seen within three half periods
  task automatic flash_chk();
    logic [1:0] seen;
    seen = 2'h0;
    repeat (12)
    begin
      tick(1);
      seen = seen | {~fault_lamp, fault_lamp};
    end
    check({6'h00, seen}, 8'h03);
  endtask

  // Raise or drop one diagnostic cause
  task automatic set_ev(input int k, input logic v);
    tick(1);
    case (k)
      0: open_fault[2] = v;
      1: in_open_pin[5] = v;
      2: gnd_fault[1] = v;
      3: out_sc_sup_pin[4] = v;
      4: param_error = v;
      5: field_supply_pin = ~v;
      default: fw_update = v;
    endcase
  endtask

  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk);
    tick(1);
    rst = 1'h0;
    flash_chk();
    params_valid = 1'h1;
    tick(6);
    check({7'h00, fault_lamp}, 8'h01);
    check({7'h00, supply_lamp}, 8'h01);
    check(fault_lamp_code, 8'h00);
    check({7'h00, fault_lamp_active}, 8'h00);
    write_image(8'hA5);
    tick(3);
    check(output_image, 8'hA5);
    check(out_drive, 8'hA5);
    check(out_lamp, 8'hA5);
    dq_enable = 8'h0F;
    tick(4);
    check(out_drive, 8'h05);
    check(out_lamp, 8'h05);
    dq_enable = 8'hFF;
    sensing_channel = 8'h3C;
    di_enable = 8'hF0;
    tick(6);
    check(input_image, 8'h30);
    check(in_lamp, 8'h30);
    check(value_status, 8'hFF);
    stuck = 8'h01;
    tick(6);
    check(value_status, 8'hFE);
    stuck = 8'h00;
    backplane_ok_pin = 1'h0;
    tick(6);
    check({7'h00, fault_lamp}, 8'h00);
    backplane_ok_pin = 1'h1;
    subst_level = 8'h3C;
    // Every stop reaction code while halted
    for (int m = 0; m < 4; m++)
    begin
      stop_mode = {8{m[1:0]}};
      host_halted = 1'h1;
      tick(6);
      check(out_drive, (m == 1) ? 8'hA5 : (m == 2) ? 8'h3C : 8'h00);
      host_halted = 1'h0;
      tick(6);
    end
    stop_mode = 16'h0000;
    fault_lamp_sc_sup_en = 1'h1;
    // Each diagnostic cause in turn
    for (int k = 0; k < 7; k++)
    begin
      set_ev(k, 1'h1);
      for (int i = 0; i < 20 && fault_lamp_irq !== 1'h1; i++)
        tick(1);
      check({7'h00, fault_lamp_irq}, 8'h01);
      check(fault_lamp_code, ev_code[k]);
      check({5'h00, fault_lamp_chan}, ev_chan[k]);
      flash_chk();
      if (k == 5)
        check({7'h00, supply_lamp}, 8'h00);
      if (k == 6)
        check(out_drive, 8'h00);
      set_ev(k, 1'h0);
      tick(10);
    end
    // Disabled input wire-break diagnostics stay silent
    fault_lamp_di_wb_en = 1'h0;
    in_open_pin[5] = 1'h1;
    tick(6);
    check({7'h00, fault_lamp_active}, 8'h00);
    check(fault_lamp_code, 8'h1F);
    in_open_pin[5] = 1'h0;
    fault_lamp_di_wb_en = 1'h1;
    results();
  end
endmodule // testbench
